// File: logic/fwu_pkg.sv
// Shared constants, types and the check-byte step function of the upgrade receiver.
package fwu_pkg;

  typedef logic [7:0] fwu_byte_t;
  typedef logic [9:0] fwu_addr_t;
  typedef logic [5:0] fwu_pos_t;

  typedef enum logic [1:0]
  {
    ST_RECV = 2'b00,
    ST_DRAIN = 2'b01,
    ST_FLASH = 2'b10
  } fwu_state_t;

  // Frame layout.
  localparam fwu_byte_t CMD_CODE = 8'h74;
  localparam fwu_byte_t RUN_PROTOCOL = 8'h00;
  localparam fwu_byte_t TAIL_VALUE = 8'h00;
  localparam fwu_pos_t CMD0_POS = 6'h00;
  localparam fwu_pos_t CMD1_POS = 6'h01;
  localparam fwu_pos_t PROTO_POS = 6'h02;
  localparam fwu_pos_t VER_POS = 6'h03;
  localparam fwu_pos_t PKT_POS = 6'h04;
  localparam fwu_pos_t CHUNK_POS = 6'h05;
  localparam fwu_pos_t PAY0_POS = 6'h06;
  localparam fwu_pos_t CHECK1_POS = 6'h0A;
  localparam fwu_pos_t SPAN2_POS = 6'h0B;
  localparam fwu_pos_t CHECK2_POS = 6'h14;
  localparam fwu_pos_t SPAN3_POS = 6'h15;
  localparam fwu_pos_t CHECK3_POS = 6'h1E;
  localparam fwu_pos_t LAST_POS = 6'h1F;
  localparam fwu_pos_t FRAME_BYTES = 6'h20;
  localparam int PAYLOAD_COUNT = 22;
  localparam fwu_addr_t PACKET_BYTES = 10'h2C0;

  // Index ranges.
  localparam fwu_byte_t MAX_PACKET = 8'h2A;
  localparam fwu_byte_t END_CHUNK = 8'h20;
  localparam fwu_pos_t LAST_CHUNK = 6'h1F;

  // Check byte: x^8 + x^5 + x^4 + 1, bit-reflected, zero seed.
  localparam fwu_byte_t CRC_POLY = 8'h8C;
  localparam fwu_byte_t CRC_SEED = 8'h00;

  // Scratchpad table choice that shows the upgrade progress.
  localparam logic [1:0] TABLE_SEL_PKT = 2'b01;

  // Reset values.
  localparam fwu_byte_t EXP_PACKET_RST = 8'h00;
  localparam fwu_byte_t EXP_VERSION_RST = 8'h00;
  localparam fwu_pos_t EXP_CHUNK_RST = 6'h00;

  function automatic fwu_byte_t fwu_crc_step(input fwu_byte_t crcIn, input fwu_byte_t dataIn);
    fwu_byte_t c;
    logic fb;
    c = crcIn;
    for (int i = 0; i < 8; i++)
    begin
      fb = c[0] ^ dataIn[i];
      c = {1'b0, c[7:1]};
      if (fb)
        c = c ^ CRC_POLY;
    end
    return c;
  endfunction

  // Maps a frame position to its slot among the 22 payload bytes.
  function automatic logic [4:0] fwu_slot(input fwu_pos_t pos);
    fwu_pos_t s;
    s = pos - PAY0_POS;
    if (pos > CHECK1_POS)
      s = s - 6'h01;
    if (pos > CHECK2_POS)
      s = s - 6'h01;
    return s[4:0];
  endfunction

endpackage

// File: logic/fwu_crc_if.sv
// Signals between the frame receiver and its check-byte engine.
`timescale 1ns/1ps
`default_nettype none
interface fwu_crc_if;
  logic feed;
  logic seed;
  logic [7:0] data;
  logic [7:0] value;

  modport engine (input feed, input seed, input data, output value);
  modport user (output feed, output seed, output data, input value);
endinterface
`default_nettype wire

// File: logic/fwu_crc8.sv
// Running check-byte engine, one byte per feed strobe.
`timescale 1ns/1ps
`default_nettype none
module fwu_crc8 (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Byte feed and result
  fwu_crc_if.engine crcBus
);
  import fwu_pkg::*;

  fwu_byte_t crc_q;
  fwu_byte_t crc_d;

  always_comb
  begin
    crc_d = fwu_crc_step(crcBus.seed ? CRC_SEED : crc_q, crcBus.data); // [R7]
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      crc_q <= CRC_SEED;
    else if (crcBus.feed)
      crc_q <= crc_d;
  end

  assign crcBus.value = crc_q;

  crc_seed_a: assert property (@(posedge clock) disable iff (rst) // [R7]
    crcBus.feed && crcBus.seed |=> crc_q == fwu_crc_step(CRC_SEED, $past(crcBus.data)))
    else $error("check byte not restarted from zero seed");

endmodule
`default_nettype wire

// File: logic/fwu_receiver.sv
// Firmware-upgrade frame receiver: framing, checks, ordering, payload and packet commit.
//
// Functional notes
// R1: Command byte 0x74 after a bus reset starts an upgrade frame.
// R2: No address; every device on the bus takes the frame.
// R3: Command code differs in two or more bits from standard codes.
// R4: A frame is exactly 32 bytes counted from the reset pulse.
// R5: Bytes 0,1 are 0x74; header, payload, checks at 10,20,30; byte 31 zero.
// R6: Checks cover bytes 2-9, 11-19 and 21-29.
// R7: Check bytes use polynomial x^8+x^5+x^4+1.
// R8: Only protocol value 0x00 is defined and handled.
// R9: Reject wrong protocol or version; version change needs packet 0, chunk 0.
// R10: Packet index 0 to 42; each packet is 704 flash bytes.
// R11: Master sends chunks 0 to 31 in increasing order.
// R12: Chunk 32 ends the last packet; device then switches firmware.
// R13: Master waits 90 ms or sends three zero frames after a packet.
// R14: Communication is off while flash is being written.
// R15: Expected packet index increments after each stored packet.
// R16: Master reads every expected index and sends the smallest.
// R17: Expected index and new version show in table bytes for choice 01.
// R18: Lower packet index with chunk 0 rewinds the expected index.
// R19: Lower packet index with nonzero chunk is ignored.
// R20: Packet above expected or chunk above next expected is ignored.
// R21: Blind master starts at packet 0, chunk 0 and restarts on failure.
// R22: Runs beside normal operation with no inter-frame time limit.
// R23: Master may resume from the read-back expected index.
// R24: Any check byte mismatch discards the frame and its payload.
`timescale 1ns/1ps
`default_nettype none
module fwu_receiver (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Byte stream from the 1-Wire front end
  input wire logic busReset,
  input wire logic rxValid,
  input wire fwu_pkg::fwu_byte_t rxByte,
  // Flash controller
  input wire logic flashDone,
  output logic writeValid,
  output fwu_pkg::fwu_addr_t writeAddr,
  output fwu_pkg::fwu_byte_t writeData,
  output logic commitValid,
  output fwu_pkg::fwu_byte_t commitPacket,
  output logic switchFirmware,
  // Link status
  output logic commOff,
  output logic frameAccept,
  // Scratchpad table
  input wire logic [1:0] tableSel,
  output fwu_pkg::fwu_byte_t tableLsb,
  output fwu_pkg::fwu_byte_t tableMsb
);
  import fwu_pkg::*;

  fwu_state_t state_q;
  fwu_pos_t pos_q;
  logic live_q;
  logic cmdOk_q;
  logic crcOk_q;
  fwu_byte_t proto_q;
  fwu_byte_t ver_q;
  fwu_byte_t pkt_q;
  fwu_byte_t chunk_q;
  fwu_byte_t stage_q [PAYLOAD_COUNT];
  fwu_byte_t expPacket_q;
  fwu_byte_t expVersion_q;
  fwu_pos_t expChunk_q;
  logic [4:0] drainIdx_q;
  fwu_addr_t drainBase_q;
  logic pending_q;
  logic final_q;
  logic writeValid_q;
  fwu_addr_t writeAddr_q;
  fwu_byte_t writeData_q;
  logic commitValid_q;
  fwu_byte_t commitPacket_q;
  logic switchFw_q;
  logic commOff_q;
  logic frameAccept_q;
  fwu_byte_t tableLsb_q;
  fwu_byte_t tableMsb_q;

  logic takeByte;
  logic evalNow;
  logic inSpan;
  logic isPayload;
  logic isCheck;
  logic versionOk;
  logic frameGood;
  logic orderOk;
  logic accept;
  logic complete;
  logic drainLast;
  fwu_pos_t chunkNorm;

  fwu_crc_if crcBus ();

  fwu_crc8 crcUnit (
    .clock(clock),
    .rst(rst),
    .crcBus(crcBus)
  );

  // Bytes are taken only inside a live frame and never while flash is written.
  assign takeByte = rxValid && live_q && !commOff_q && (pos_q < FRAME_BYTES); // [R4] [R14]
  assign evalNow = takeByte && (pos_q == LAST_POS); // [R4]
  assign inSpan = ((pos_q >= PROTO_POS) && (pos_q < CHECK1_POS)) ||
                  ((pos_q >= SPAN2_POS) && (pos_q < CHECK2_POS)) ||
                  ((pos_q >= SPAN3_POS) && (pos_q < CHECK3_POS)); // [R6]
  assign isPayload = inSpan && (pos_q >= PAY0_POS); // [R5]
  assign isCheck = (pos_q == CHECK1_POS) || (pos_q == CHECK2_POS) || (pos_q == CHECK3_POS); // [R5] [R6]

  assign crcBus.feed = takeByte && inSpan; // [R6]
  assign crcBus.seed = (pos_q == PROTO_POS) || (pos_q == SPAN2_POS) || (pos_q == SPAN3_POS); // [R6]
  assign crcBus.data = rxByte;

  // Frame tracking; a reset pulse during a flash write starts no frame.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pos_q <= 6'h00;
      live_q <= 1'b0;
    end
    else if (busReset)
    begin
      pos_q <= 6'h00;
      live_q <= !commOff_q; // [R14]
    end
    else if (commOff_q)
      live_q <= 1'b0; // [R14]
    else if (takeByte)
    begin
      pos_q <= pos_q + 6'h01; // [R4]
      if (evalNow)
        live_q <= 1'b0;
    end
  end

  // Header fields and per-frame check results.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cmdOk_q <= 1'b0;
      crcOk_q <= 1'b0;
      proto_q <= 8'h00;
      ver_q <= 8'h00;
      pkt_q <= 8'h00;
      chunk_q <= 8'h00;
    end
    else if (busReset)
    begin
      cmdOk_q <= 1'b1;
      crcOk_q <= 1'b1;
    end
    else if (takeByte)
    begin
      if ((pos_q == CMD0_POS) || (pos_q == CMD1_POS))
        cmdOk_q <= cmdOk_q && (rxByte == CMD_CODE); // [R1] [R3] [R5]
      else if (pos_q == PROTO_POS)
        proto_q <= rxByte;
      else if (pos_q == VER_POS)
        ver_q <= rxByte;
      else if (pos_q == PKT_POS)
        pkt_q <= rxByte;
      else if (pos_q == CHUNK_POS)
        chunk_q <= rxByte;
      else if (isCheck)
        crcOk_q <= crcOk_q && (crcBus.value == rxByte); // [R6] [R24]
    end
  end

  // Payload staging; nothing reaches flash before the whole frame has checked out.
  generate
    for (genvar i = 0; i < PAYLOAD_COUNT; i++)
    begin : gStage
      always_ff @(posedge clock)
      begin
        if (rst)
          stage_q[i] <= 8'h00;
        else if (takeByte && isPayload && (fwu_slot(pos_q) == 5'(i)))
          stage_q[i] <= rxByte; // [R24]
      end
    end
  endgenerate

  // Final acceptance is decided as byte 31 arrives.
  assign chunkNorm = (chunk_q == END_CHUNK) ? LAST_CHUNK : chunk_q[5:0]; // [R12]
  assign versionOk = (ver_q == expVersion_q) || ((pkt_q == 8'h00) && (chunk_q == 8'h00)); // [R9]
  assign frameGood = cmdOk_q && crcOk_q && (rxByte == TAIL_VALUE) &&
                     (proto_q == RUN_PROTOCOL) && versionOk &&
                     (pkt_q <= MAX_PACKET) && (chunk_q <= END_CHUNK); // [R5] [R8] [R9] [R10] [R24]
  // Any device takes the frame; there is no address match.
  assign orderOk = (pkt_q < expPacket_q) ? (chunk_q == 8'h00) :
                   ((pkt_q == expPacket_q) && (chunkNorm <= expChunk_q)); // [R2] [R18] [R19] [R20]
  assign accept = evalNow && frameGood && orderOk && (state_q == ST_RECV);
  assign complete = (chunkNorm == LAST_CHUNK); // [R12]
  assign drainLast = (drainIdx_q == 5'(PAYLOAD_COUNT - 1));

  // Progress state; no timer runs between frames, so reception may take any time.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      expPacket_q <= EXP_PACKET_RST;
      expChunk_q <= EXP_CHUNK_RST;
      expVersion_q <= EXP_VERSION_RST;
    end
    else if (accept)
    begin
      expPacket_q <= pkt_q; // [R18] [R22]
      expChunk_q <= chunkNorm + 6'h01; // [R20]
      expVersion_q <= ver_q; // [R9]
    end
    else if (commitValid_q)
    begin
      expPacket_q <= expPacket_q + 8'h01; // [R15]
      expChunk_q <= EXP_CHUNK_RST;
    end
  end

  // Payload drain and flash hand-off.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= ST_RECV;
      drainIdx_q <= 5'h00;
      drainBase_q <= 10'h000;
      pending_q <= 1'b0;
      final_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_RECV:
        begin
          if (accept)
          begin
            state_q <= ST_DRAIN;
            drainIdx_q <= 5'h00;
            drainBase_q <= 10'(chunkNorm * PAYLOAD_COUNT); // [R10]
            pending_q <= complete;
            final_q <= (chunk_q == END_CHUNK); // [R12]
          end
        end
        ST_DRAIN:
        begin
          drainIdx_q <= drainIdx_q + 5'h01;
          if (drainLast)
            state_q <= pending_q ? ST_FLASH : ST_RECV;
        end
        ST_FLASH:
        begin
          if (flashDone)
            state_q <= ST_RECV;
        end
        default:
          state_q <= ST_RECV;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      writeValid_q <= 1'b0;
      writeAddr_q <= 10'h000;
      writeData_q <= 8'h00;
    end
    else
    begin
      writeValid_q <= (state_q == ST_DRAIN);
      writeAddr_q <= drainBase_q + 10'(drainIdx_q); // [R10]
      writeData_q <= stage_q[drainIdx_q];
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      commitValid_q <= 1'b0;
      commitPacket_q <= 8'h00;
      switchFw_q <= 1'b0;
    end
    else
    begin
      commitValid_q <= (state_q == ST_DRAIN) && drainLast && pending_q; // [R15]
      commitPacket_q <= expPacket_q;
      switchFw_q <= (state_q == ST_DRAIN) && drainLast && pending_q && final_q; // [R12]
    end
  end

  // Communication goes off as soon as a packet completes, until flash reports done.
  always_ff @(posedge clock)
  begin
    if (rst)
      commOff_q <= 1'b0;
    else if (accept && complete)
      commOff_q <= 1'b1; // [R14]
    else if ((state_q == ST_FLASH) && flashDone)
      commOff_q <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      frameAccept_q <= 1'b0;
      tableLsb_q <= 8'h00;
      tableMsb_q <= 8'h00;
    end
    else
    begin
      frameAccept_q <= accept;
      tableLsb_q <= (tableSel == TABLE_SEL_PKT) ? expPacket_q : 8'h00; // [R17]
      tableMsb_q <= (tableSel == TABLE_SEL_PKT) ? expVersion_q : 8'h00; // [R17]
    end
  end

  assign writeValid = writeValid_q;
  assign writeAddr = writeAddr_q;
  assign writeData = writeData_q;
  assign commitValid = commitValid_q;
  assign commitPacket = commitPacket_q;
  assign switchFirmware = switchFw_q;
  assign commOff = commOff_q;
  assign frameAccept = frameAccept_q;
  assign tableLsb = tableLsb_q;
  assign tableMsb = tableMsb_q;

  sequence drainRun;
    writeValid_q [*8];
  endsequence

  sequence noDrain;
    !frameAccept_q ##1 !writeValid_q;
  endsequence

  accept_drain_a: assert property (@(posedge clock) disable iff (rst) // [R5]
    frameAccept_q |=> drainRun)
    else $error("accepted frame did not drain its payload");

  cmd_seen_a: assert property (@(posedge clock) disable iff (rst) // [R1]
    frameAccept_q |-> $past(cmdOk_q))
    else $error("frame accepted without command bytes");

  crc_drop_a: assert property (@(posedge clock) disable iff (rst) // [R24]
    evalNow && !crcOk_q && (state_q == ST_RECV) |=> noDrain)
    else $error("frame with bad check byte was used");

  rewind_index_a: assert property (@(posedge clock) disable iff (rst) // [R18]
    accept && (pkt_q < expPacket_q) |=> (expPacket_q == $past(pkt_q)) && (expChunk_q == 6'h01))
    else $error("rewind did not restart at the lower packet");

  lower_ignore_a: assert property (@(posedge clock) disable iff (rst) // [R19]
    evalNow && (state_q == ST_RECV) && (pkt_q < expPacket_q) && (chunk_q != 8'h00)
    |=> $stable(expPacket_q) && $stable(expChunk_q))
    else $error("lower packet with nonzero chunk changed progress");

  ahead_ignore_a: assert property (@(posedge clock) disable iff (rst) // [R20]
    evalNow && ((pkt_q > expPacket_q) || ((pkt_q == expPacket_q) && (chunkNorm > expChunk_q)))
    |=> !frameAccept_q)
    else $error("out-of-order frame was accepted");

  commit_step_a: assert property (@(posedge clock) disable iff (rst) // [R15]
    commitValid_q |=> expPacket_q == $past(commitPacket_q) + 8'h01)
    else $error("expected packet did not advance after commit");

  flash_quiet_a: assert property (@(posedge clock) disable iff (rst) // [R14]
    commitValid_q |-> commOff_q ##1 (commOff_q && !live_q))
    else $error("link active during flash write");

  switch_commit_a: assert property (@(posedge clock) disable iff (rst) // [R12]
    switchFw_q |-> commitValid_q && final_q)
    else $error("firmware switch outside a final commit");

endmodule
`default_nettype wire

// File: verification/fwu_master_model.sv
// Byte-stream model of the upgrade master that feeds the receiver.
`timescale 1ns/1ps
`default_nettype none
module fwu_master_model (
  // Clock
  input wire logic clock,
  // Byte stream to the receiver
  output logic busReset,
  output logic rxValid,
  output fwu_pkg::fwu_byte_t rxByte
);
  import fwu_pkg::*;

  initial
  begin
    busReset = 1'b0;
    rxValid = 1'b0;
    rxByte = 8'h5A;
  end

  function automatic fwu_byte_t crc(input fwu_byte_t f[32], input int a, input int b);
    fwu_byte_t c;
    logic fb;
    c = 8'h00;
    for (int j = a; j <= b; j++)
      for (int k = 0; k < 8; k++)
      begin
        fb = c[0] ^ f[j][k];
        c = {1'b0, c[7:1]};
        if (fb)
          c = c ^ CRC_POLY;
      end
    return c;
  endfunction

  // Payload bytes carry their packet address so the far end can be checked.
  task automatic send(input fwu_byte_t ver, input fwu_byte_t pkt, input fwu_byte_t chk, input logic bad);
    fwu_byte_t f[32];
    int s;
    int base;
    base = ((chk == END_CHUNK) ? 31 : int'(chk)) * 22;
    s = 0;
    foreach (f[p])
      f[p] = 8'h00;
    f[0] = CMD_CODE;
    f[1] = CMD_CODE;
    f[2] = RUN_PROTOCOL;
    f[3] = ver;
    f[4] = pkt;
    f[5] = chk;
    for (int p = 6; p < 30; p++)
      if (p != 10 && p != 20)
      begin
        f[p] = 8'(base + s) ^ 8'hA5;
        s++;
      end
    f[10] = crc(f, 2, 9);
    f[20] = crc(f, 11, 19);
    f[30] = crc(f, 21, 29) ^ {7'h00, bad};
    @(negedge clock);
    busReset = 1'b1;
    @(negedge clock);
    busReset = 1'b0;
    for (int p = 0; p < 32; p++)
    begin
      rxValid = 1'b1;
      rxByte = f[p];
      @(negedge clock);
    end
    rxValid = 1'b0;
    // A released line shows the inverse of its last value.
    rxByte = ~rxByte;
  endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
// Self-checking testbench of the upgrade frame receiver.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fwu_pkg::*;

  logic clock, rst, flashDone, busReset, rxValid;
  logic writeValid, commitValid, switchFirmware, commOff, frameAccept;
  fwu_byte_t rxByte, writeData, commitPacket, tableLsb, tableMsb, lastPkt;
  fwu_addr_t writeAddr, lastAddr;
  logic [1:0] tableSel;
  int miscompares = 0;
  int tests_run = 0;
  int accCnt = 0;
  int wrCnt = 0;
  int comCnt = 0;
  int swCnt = 0;

  always #2 clock = ~clock;

  fwu_master_model m (.clock(clock), .busReset(busReset), .rxValid(rxValid), .rxByte(rxByte));

  fwu_receiver uut (.clock(clock), .rst(rst), .busReset(busReset), .rxValid(rxValid), .rxByte(rxByte),
    .flashDone(flashDone), .writeValid(writeValid), .writeAddr(writeAddr), .writeData(writeData),
    .commitValid(commitValid), .commitPacket(commitPacket), .switchFirmware(switchFirmware),
    .commOff(commOff), .frameAccept(frameAccept), .tableSel(tableSel), .tableLsb(tableLsb),
    .tableMsb(tableMsb));

  // Automatic, because the output monitor and the scenarios may both call it on one edge.
  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Outputs are sampled at the falling edge, well after the rising edge that launches them.
  always @(negedge clock)
  begin
    if (frameAccept === 1'b1)
      accCnt++;
    if (writeValid === 1'b1)
    begin
      wrCnt++;
      lastAddr = writeAddr;
      check("writeData", {2'b00, writeData}, {2'b00, writeAddr[7:0] ^ 8'hA5});
    end
    if (commitValid === 1'b1)
    begin
      comCnt++;
      lastPkt = commitPacket;
    end
    if (switchFirmware === 1'b1)
      swCnt++;
  end

  task frame(input fwu_byte_t ver, input fwu_byte_t pkt, input fwu_byte_t chk, input logic bad, input int acc);
    int a0;
    int w0;
    a0 = accCnt;
    w0 = wrCnt;
    m.send(ver, pkt, chk, bad);
    repeat (30) @(negedge clock);
    check("accepted", 10'(accCnt - a0), 10'(acc));
    check("writes", 10'(wrCnt - w0), 10'(acc * 22));
    if (acc == 1)
      check("lastAddr", lastAddr, 10'(((chk == END_CHUNK) ? 31 : int'(chk)) * 22 + 21));
  endtask

  task test_done;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task t_first;
    frame(8'h05, 8'h00, 8'h00, 1'b0, 1);
    check("tableLsb", {2'b00, tableLsb}, 10'h000);
    check("tableMsb", {2'b00, tableMsb}, 10'h005);
    tableSel = 2'b00;
    repeat (3) @(negedge clock);
    check("tableOther", {2'b00, tableMsb}, 10'h000);
    tableSel = 2'b01;
    $display("test first done");
  endtask

  task t_refuse;
    frame(8'h05, 8'h00, 8'h01, 1'b1, 0);
    frame(8'h05, 8'h00, 8'h02, 1'b0, 0);
    frame(8'h05, 8'h01, 8'h01, 1'b0, 0);
    frame(8'h06, 8'h00, 8'h01, 1'b0, 0);
    $display("test refuse done");
  endtask

  task t_packet;
    for (int c = 1; c < 32; c++)
      frame(8'h05, 8'h00, 8'(c), 1'b0, 1);
    check("commits", 10'(comCnt), 10'h001);
    check("commitPacket", {2'b00, lastPkt}, 10'h000);
    check("commOffOn", {9'h000, commOff}, 10'h001);
    frame(8'h05, 8'h01, 8'h00, 1'b0, 0);
    flashDone = 1'b1;
    @(negedge clock);
    flashDone = 1'b0;
    repeat (3) @(negedge clock);
    check("commOffOff", {9'h000, commOff}, 10'h000);
    check("nextPacket", {2'b00, tableLsb}, 10'h001);
    $display("test packet done");
  endtask

  task t_rewind;
    frame(8'h05, 8'h00, 8'h05, 1'b0, 0);
    frame(8'h05, 8'h02, 8'h00, 1'b0, 0);
    repeat (2000) @(negedge clock);
    frame(8'h05, 8'h00, 8'h00, 1'b0, 1);
    check("rewound", {2'b00, tableLsb}, 10'h000);
    $display("test rewind done");
  endtask

  task t_final;
    for (int c = 1; c < 31; c++)
      frame(8'h05, 8'h00, 8'(c), 1'b0, 1);
    frame(8'h05, 8'h00, END_CHUNK, 1'b0, 1);
    check("switches", 10'(swCnt), 10'h001);
    check("commits", 10'(comCnt), 10'h002);
    check("finalPacket", {2'b00, lastPkt}, 10'h000);
    $display("test final done");
  endtask

  initial
  begin
    clock = 1'b0;
    rst = 1'b1;
    flashDone = 1'b0;
    tableSel = 2'b01;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    t_first;
    t_refuse;
    t_packet;
    t_rewind;
    t_final;
    test_done;
  end

  // 71 frames of about 64 cycles plus idle time fit well inside this span.
  initial
  begin
    #200000;
    miscompares++;
    test_done;
  end
endmodule
`default_nettype wire
